// >>> src/chip_select_decode_overlap.sv
// Chip-select decoder with overlap handling, wait-state and ready sequencing.
// Assumes one bus cycle request at a time, inputs synchronous to hclk.
//
// The AHB-Lite register port and the register addresses were decided locally.
`include "cs_decode_map.svh"

module chip_select_decode_overlap (
    input  wire logic        hclk,              // System clock
    input  wire logic        hresetn,           // Async reset, active low
    input  wire logic        hsel,              // AHB slave select
    input  wire logic [31:0] haddr,             // AHB address
    input  wire logic [1:0]  htrans,            // AHB transfer type
    input  wire logic        hwrite,            // AHB write
    input  wire logic [2:0]  hsize,             // AHB size
    input  wire logic [31:0] hwdata,            // AHB write data
    input  wire logic        hready,            // AHB bus ready
    output logic      [31:0] hrdata,            // AHB read data
    output logic             hreadyout,         // AHB slave ready
    output logic             hresp,             // AHB response
    input  wire logic        boot_width_strap,  // High selects 16-bit boot
    input  wire logic        cyc_start,         // Bus cycle start pulse
    input  wire logic [19:0] cyc_addr,          // Cycle physical address
    input  wire logic        cyc_io,            // Cycle is in I/O space
    input  wire logic        async_ready_in,    // External ready, async kind
    input  wire logic        sync_ready_in,     // External ready, sync kind
    output logic             cyc_busy,          // Cycle in progress
    output logic             cyc_done,          // Cycle ends, one pulse
    output logic             cyc_width16,       // Cycle bus width is 16
    output logic             addr_drive_en,     // Address may drive AD bus
    output logic             upper_mem_select_n,// Upper memory select
    output logic             low_mem_select_n,  // Low select or bank 0 row
    output logic [3:0]       mid_pin_n,         // Midrange pins
    output logic [6:0]       periph_select_n    // Peripheral pins
);
    logic [15:0] upper_mem_ctrl;
    logic [15:0] low_mem_ctrl;
    logic [15:0] mid_mem_ctrl;
    logic [15:0] mid_periph_ctrl;
    logic [15:0] periph_base_ctrl;
    logic [15:0] aux_config;
    logic [15:0] pcb_reloc;
    logic        mid_wr;
    logic        midper_wr;
    logic        perbase_wr;
    logic        boot8;
    logic        strap_done;
    logic        wr_pend;
    logic [7:0]  wr_ofs;
    cs_decode_pkg::cyc_state_e state;
    cs_decode_pkg::wait_t      wcnt;
    logic        h_up;
    logic        h_low;
    logic [3:0]  h_mid;
    logic [6:0]  h_per;
    logic        h_pcb;
    logic        h_dram;
    logic        h_bank1;
    logic        h_ready_req;
    logic        h_da;
    logic        h_w16;
    logic        any_dram;
    logic        dram1;
    logic        a2_lat;
    logic        a1_lat;
    // Decode results for the cycle being requested.
    logic        up_hit;
    logic        low_hit;
    logic        bank1_hit;
    logic        per_blk;
    logic        mid_blk;
    logic [6:0]  per_hit;
    logic [3:0]  mid_hit;
    logic        pcb_hit;
    logic        dram_hit;
    logic        next_rdy;
    logic        next_w16;
    cs_decode_pkg::wait_t next_wait;

    function automatic cs_decode_pkg::wait_t wait_code(input logic [2:0] c);
        case (c)
            3'h4:    wait_code = 4'h5;
            3'h5:    wait_code = 4'h7;
            3'h6:    wait_code = 4'h9;
            3'h7:    wait_code = 4'hF;
            default: wait_code = {2'h0, c[1:0]};
        endcase
    endfunction : wait_code

    function automatic cs_decode_pkg::wait_t wmax(input cs_decode_pkg::wait_t a,
                                                  input cs_decode_pkg::wait_t b);
        wmax = (a > b) ? a : b;
    endfunction : wmax

    function automatic logic [15:0] reg_read(input logic [7:0] ofs);
        case (ofs)
            `OFS_UPPER:   reg_read = upper_mem_ctrl & `MSK_UPPER;
            `OFS_LOW:     reg_read = low_mem_ctrl & `MSK_LOW;
            `OFS_MID:     reg_read = mid_mem_ctrl & `MSK_MID;
            `OFS_MIDPER:  reg_read = mid_periph_ctrl & `MSK_MIDPER;
            `OFS_PERBASE: reg_read = periph_base_ctrl & `MSK_PERBASE;
            `OFS_AUX:     reg_read = aux_config & `MSK_AUX;
            `OFS_PCB:     reg_read = pcb_reloc & `MSK_PCB;
            `OFS_STATUS:  reg_read = {2'h0, h_pcb, h_per, h_mid, h_low, h_up};
            default:      reg_read = 16'h0000;
        endcase
    endfunction : reg_read

    assign any_dram = low_mem_ctrl[`BIT_DRAM0] | low_mem_ctrl[`BIT_DRAM1];
    assign dram1    = low_mem_ctrl[`BIT_DRAM1];

    // Bus slave: zero-wait, always OKAY, read data prepared in address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
            wr_pend   <= 1'b0;
            wr_ofs    <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= 1'b0;
            if (hsel && hready && htrans[1]) begin
                wr_pend <= hwrite;
                wr_ofs  <= {haddr[7:2], 2'h0};
                if (!hwrite) begin
                    hrdata <= {16'h0000, reg_read({haddr[7:2], 2'h0})};
                end
            end
        end
    end

    // Register writes; a write to the midrange or peripheral registers enables their logic.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upper_mem_ctrl   <= `RST_UPPER;
            low_mem_ctrl     <= `RST_ZERO;
            mid_mem_ctrl     <= `RST_ZERO;
            mid_periph_ctrl  <= `RST_ZERO;
            periph_base_ctrl <= `RST_ZERO;
            pcb_reloc        <= `RST_PCB;
            mid_wr           <= 1'b0;
            midper_wr        <= 1'b0;
            perbase_wr       <= 1'b0;
        end else if (wr_pend) begin
            case (wr_ofs)
                `OFS_UPPER:   upper_mem_ctrl <= hwdata[15:0];
                `OFS_LOW:     low_mem_ctrl <= hwdata[15:0];
                `OFS_MID: begin
                    mid_mem_ctrl <= hwdata[15:0];
                    mid_wr       <= 1'b1;
                end
                `OFS_MIDPER: begin
                    mid_periph_ctrl <= hwdata[15:0];
                    midper_wr       <= 1'b1;
                end
                `OFS_PERBASE: begin
                    periph_base_ctrl <= hwdata[15:0];
                    perbase_wr       <= 1'b1;
                end
                `OFS_PCB:     pcb_reloc <= hwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // Width bits; the boot strap is caught on the first edge after release.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_config <= `RST_ZERO;
            boot8      <= 1'b0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            strap_done            <= 1'b1;
            boot8                 <= ~boot_width_strap;
            aux_config[`BIT_W_UP] <= ~boot_width_strap;
        end else if (wr_pend && wr_ofs == `OFS_AUX) begin
            aux_config[`BIT_W_IO]  <= hwdata[`BIT_W_IO];
            aux_config[`BIT_W_MID] <= hwdata[`BIT_W_MID];
            aux_config[`BIT_W_LOW] <= hwdata[`BIT_W_LOW];
            if (boot8) begin
                aux_config[`BIT_W_UP] <= hwdata[`BIT_W_UP];
            end
        end
    end

    // Address decode of every enabled select for the requested cycle.
    always_comb begin
        up_hit    = !cyc_io && cyc_addr[19:12] >= upper_mem_ctrl[15:8];
        low_hit   = !cyc_io && low_mem_ctrl[`BIT_LOW_EN]
                    && cyc_addr[19:12] <= low_mem_ctrl[15:8];
        bank1_hit = dram1 && !cyc_io && !up_hit && !low_hit;
        per_blk   = perbase_wr && midper_wr
                    && (mid_periph_ctrl[`BIT_PER_MEM] ? !cyc_io : cyc_io)
                    && cyc_addr[19:11] == periph_base_ctrl[15:7];
        for (int i = 0; i < 7; i++) begin
            per_hit[i] = per_blk && cyc_addr[10:8] == i[2:0];
        end
        if (mid_periph_ctrl[`BIT_PER_ABITS]) begin
            per_hit[6:5] = 2'b00;
        end
        mid_blk = mid_wr && midper_wr && !cyc_io
                  && cyc_addr[19:16] == mid_mem_ctrl[15:12]
                  && !up_hit && !low_hit
                  && !(mid_periph_ctrl[`BIT_PER_MEM] && |per_hit);
        for (int i = 0; i < 4; i++) begin
            if (mid_periph_ctrl[`BIT_MIDRANGE_SELECT_FIRST_ALL]) begin
                mid_hit[i] = mid_blk && i == 0;
            end else begin
                mid_hit[i] = mid_blk && cyc_addr[15:14] == i[1:0];
            end
        end
        pcb_hit  = (pcb_reloc[`BIT_PCB_IO] ? cyc_io : !cyc_io)
                   && cyc_addr[19:8] == pcb_reloc[15:4];
        dram_hit = (low_hit && low_mem_ctrl[`BIT_DRAM0]) || bank1_hit;
    end

    // Combined ready and wait requirements of the asserted memory selects; a peripheral hit replaces them.
    always_comb begin
        next_wait = 4'h0;
        next_rdy  = 1'b0;
        if (up_hit) begin
            next_wait = wmax(next_wait, {2'h0, upper_mem_ctrl[1:0]});
            next_rdy  = next_rdy | !upper_mem_ctrl[`BIT_RDY_IGN];
        end
        if (low_hit || bank1_hit) begin
            next_wait = wmax(next_wait, {2'h0, low_mem_ctrl[1:0]});
            next_rdy  = next_rdy | !low_mem_ctrl[`BIT_RDY_IGN];
        end
        if (|mid_hit || (mid_blk && any_dram)) begin
            next_wait = wmax(next_wait, {2'h0, mid_mem_ctrl[1:0]});
            next_rdy  = next_rdy | !mid_mem_ctrl[`BIT_RDY_IGN];
        end
        // Overlapping selects are programmed alike; peripheral over DRAM wins.
        if (|per_hit[4:0]) begin
            next_wait = wait_code(periph_base_ctrl[2:0]);
            next_rdy  = !periph_base_ctrl[`BIT_PER_RDY];
        end
        if (|per_hit[6:5]) begin
            next_wait = {2'h0, mid_periph_ctrl[1:0]};
            next_rdy  = !mid_periph_ctrl[`BIT_RDY_IGN];
        end
    end

    // Bus width of the cycle.
    always_comb begin
        if (|per_hit && dram_hit) begin
            next_w16 = low_hit ? !aux_config[`BIT_W_LOW]
                               : !aux_config[`BIT_W_UP];
        end else if (|per_hit && cyc_io) begin
            next_w16 = !aux_config[`BIT_W_IO];
        end else if (up_hit) begin
            next_w16 = !aux_config[`BIT_W_UP];
        end else if (low_hit) begin
            next_w16 = !aux_config[`BIT_W_LOW];
        end else if (bank1_hit) begin
            next_w16 = !aux_config[`BIT_W_UP];
        end else begin
            next_w16 = !aux_config[`BIT_W_MID];
        end
    end

    // Cycle sequencer: capture decode, count waits, then honour ready.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state       <= cs_decode_pkg::ST_IDLE;
            wcnt        <= 4'h0;
            h_up        <= 1'b0;
            h_low       <= 1'b0;
            h_mid       <= 4'h0;
            h_per       <= 7'h00;
            h_pcb       <= 1'b0;
            h_dram      <= 1'b0;
            h_bank1     <= 1'b0;
            h_ready_req <= 1'b0;
            h_da        <= 1'b0;
            h_w16       <= 1'b0;
            a2_lat      <= 1'b0;
            a1_lat      <= 1'b0;
            cyc_done    <= 1'b0;
            cyc_busy    <= 1'b0;
        end else begin
            cyc_done <= 1'b0;
            case (state)
                cs_decode_pkg::ST_IDLE: begin
                    if (cyc_start) begin
                        state       <= cs_decode_pkg::ST_ADDR;
                        cyc_busy    <= 1'b1;
                        h_up        <= up_hit;
                        h_low       <= low_hit;
                        h_bank1     <= bank1_hit;
                        h_mid       <= mid_hit;
                        h_per       <= per_hit;
                        h_pcb       <= pcb_hit;
                        h_dram      <= dram_hit;
                        h_ready_req <= next_rdy;
                        wcnt        <= next_wait;
                        h_w16       <= next_w16;
                        h_da        <= (up_hit && upper_mem_ctrl[`BIT_DA])
                                       || (low_hit && low_mem_ctrl[`BIT_DA]);
                        a2_lat      <= cyc_addr[2];
                        a1_lat      <= cyc_addr[1];
                    end
                end
                cs_decode_pkg::ST_ADDR: begin
                    state <= cs_decode_pkg::ST_WAIT;
                end
                cs_decode_pkg::ST_WAIT: begin
                    if (wcnt != 4'h0) begin
                        wcnt <= wcnt - 4'h1;
                    end else if (!h_ready_req || async_ready_in || sync_ready_in) begin
                        state    <= cs_decode_pkg::ST_IDLE;
                        cyc_done <= 1'b1;
                        cyc_busy <= 1'b0;
                        h_up     <= 1'b0;
                        h_low    <= 1'b0;
                        h_mid    <= 4'h0;
                        h_per    <= 7'h00;
                        h_pcb    <= 1'b0;
                        h_dram   <= 1'b0;
                        h_bank1  <= 1'b0;
                        h_da     <= 1'b0;
                    end
                end
                default: begin
                    state <= cs_decode_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Pin drivers. Upper and low follow the early address timing; midrange
    // and peripheral pins wait for the multiplexed address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upper_mem_select_n <= 1'b1;
            low_mem_select_n   <= 1'b1;
            mid_pin_n          <= 4'hF;
            periph_select_n    <= 7'h7F;
            addr_drive_en      <= 1'b1;
            cyc_width16        <= 1'b0;
        end else begin
            cyc_width16        <= h_w16;
            addr_drive_en      <= !h_da;
            upper_mem_select_n <= !(cyc_busy && !cyc_done && h_up);
            // Low pin doubles as bank 0 row strobe in DRAM mode.
            low_mem_select_n   <= !(cyc_busy && !cyc_done && h_low);
            if (state == cs_decode_pkg::ST_WAIT && !cyc_done) begin
                mid_pin_n[0] <= !h_mid[0];
                if (any_dram) begin
                    // Column strobes stay off when a peripheral overlaps DRAM.
                    mid_pin_n[1] <= !(h_dram && !(|h_per));
                    mid_pin_n[2] <= !(h_dram && !(|h_per));
                end else begin
                    mid_pin_n[1] <= !h_mid[1];
                    mid_pin_n[2] <= !h_mid[2];
                end
                mid_pin_n[3] <= dram1 ? !h_bank1 : !h_mid[3];
                periph_select_n[3:0] <= ~h_per[3:0];
                periph_select_n[4]   <= 1'b1;
                if (mid_periph_ctrl[`BIT_PER_ABITS]) begin
                    periph_select_n[6] <= a2_lat;
                    periph_select_n[5] <= a1_lat;
                end else begin
                    periph_select_n[6:5] <= ~h_per[6:5];
                end
            end else begin
                mid_pin_n            <= 4'hF;
                periph_select_n[4:0] <= 5'h1F;
                if (mid_periph_ctrl[`BIT_PER_ABITS]) begin
                    periph_select_n[6] <= a2_lat;
                    periph_select_n[5] <= a1_lat;
                end else begin
                    periph_select_n[6:5] <= 2'b11;
                end
            end
        end
    end

endmodule : chip_select_decode_overlap

// >>> src/cs_decode_map.svh
// Constants of the chip-select decoder: register offsets, field positions,
// reset values and masks.
// Assumes a 32-bit AHB-Lite bus with each register in the low half of a word.
`ifndef CS_DECODE_MAP_SVH
`define CS_DECODE_MAP_SVH

`define OFS_UPPER      8'h00
`define OFS_LOW        8'h04
`define OFS_MID        8'h08
`define OFS_MIDPER     8'h0C
`define OFS_PERBASE    8'h10
`define OFS_AUX        8'h14
`define OFS_PCB        8'h18
`define OFS_STATUS     8'h1C

`define RST_UPPER      16'hF003
`define RST_ZERO       16'h0000
`define RST_PCB        16'hFF01

`define MSK_UPPER      16'hFF87
`define MSK_LOW        16'hFFE7
`define MSK_MID        16'hF007
`define MSK_MIDPER     16'h00E7
`define MSK_PERBASE    16'hFF8F
`define MSK_AUX        16'h000F
`define MSK_PCB        16'hFFF1

`define BIT_DA         7
`define BIT_DRAM0      6
`define BIT_DRAM1      5
`define BIT_LOW_EN     3
`define BIT_RDY_IGN    2
`define BIT_MIDRANGE_SELECT_FIRST_ALL   7
`define BIT_PER_MEM    6
`define BIT_PER_ABITS  5
`define BIT_PER_RDY    3
`define BIT_PCB_IO     0
`define BIT_W_IO       0
`define BIT_W_MID      1
`define BIT_W_LOW      2
`define BIT_W_UP       3

`endif

// >>> src/cs_decode_pkg.sv
// Types of the chip-select decoder.
// Assumes the constants header is included by files that need offsets.
package cs_decode_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_WAIT = 2'b10
    } cyc_state_e;
    typedef logic [3:0] wait_t;
endpackage : cs_decode_pkg

// >>> tb/chip_select_decode_overlap_test.sv
// Self-checking bench of the chip-select decoder.
// Assumes the ready model answers for the upper and low selects.
`include "cs_decode_map.svh"
module chip_select_decode_overlap_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        cyc_start = 1'b0, cyc_io = 1'b0, boot_width_strap = 1'b1;
    logic        sync_ready_in = 1'b0, async_ready_in, w16;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, len;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [19:0] cyc_addr = 20'h0;
    logic        hreadyout, hresp, cyc_busy, cyc_done, cyc_width16, addr_drive_en;
    logic        upper_mem_select_n, low_mem_select_n;
    logic [3:0]  mid_pin_n;
    logic [5:0]  seen;
    logic [6:0]  periph_select_n;
    logic [7:0]  dly = 8'h00;
    int          error_cnt = 0, checks = 0;
    wire logic   hready = hreadyout;
    always #5 hclk = ~hclk;
    chip_select_decode_overlap uut (.*);
    cs_ready_model partner (.hclk(hclk), .hresetn(hresetn), .dly(dly),
        .sel_n({upper_mem_select_n, low_mem_select_n}), .ready(async_ready_in));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic rst(input logic strap);
        hresetn <= 1'b0;
        boot_width_strap <= strap;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask : rst
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // Records which outputs went low during one cycle and how long it ran.
    task automatic cyc(input logic [19:0] a, input logic io);
        cyc_start <= 1'b1;
        cyc_addr <= a;
        cyc_io <= io;
        @(posedge hclk);
        cyc_start <= 1'b0;
        len = 32'h0;
        seen = 6'h00;
        do begin
            @(posedge hclk);
            #1;
            len++;
            w16 = cyc_width16;
            seen |= ~{periph_select_n[1], mid_pin_n[1], upper_mem_select_n,
                      low_mem_select_n, mid_pin_n[0], addr_drive_en};
        end while (cyc_done !== 1'b1 && len < 32'd100);
        chk("cyc_done", 32'h1, {31'h0, cyc_done});
        @(posedge hclk);
    endtask : cyc
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        rst(1'b1);
        bus(1'b0, `OFS_UPPER, 32'h0);
        chk("upper_mem_ctrl", 32'hF003, rd);
        bus(1'b0, `OFS_LOW, 32'h0);
        chk("low_mem_ctrl", 32'h0, rd);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b0, `OFS_AUX, 32'h0);
        chk("aux_config", 32'h0, rd);
        bus(1'b1, `OFS_AUX, 32'hF);
        bus(1'b0, `OFS_AUX, 32'h0);
        chk("aux_config", 32'h7, rd);
        $display("test registers done");
        cyc(20'hFFFF0, 1'b0);
        chk("upper sel", 32'h1, seen[3]);
        chk("drive off", 32'h0, seen[0]);
        chk("width16", 32'h1, w16);
        chk("fast len", 32'd5, len);
        dly <= 8'd10;
        cyc(20'hFFFF0, 1'b0);
        chk("slow len", 32'h1, len >= 32'd12);
        dly <= 8'hFF;
        sync_ready_in <= 1'b1;
        cyc(20'hFFFF0, 1'b0);
        chk("sync len", 32'd5, len);
        sync_ready_in <= 1'b0;
        cyc(20'hEFFF0, 1'b0);
        chk("below upper", 32'h0, seen[3]);
        cyc(20'h00100, 1'b0);
        chk("low off", 32'h0, seen[2]);
        $display("test upper done");
        for (int w = 0; w < 4; w++) begin
            bus(1'b1, `OFS_LOW, 32'h0F0C | w);
            cyc(20'h00100, 1'b0);
            chk("low sel", 32'h1, seen[2]);
            chk("low len", 32'(2 + w), len);
        end
        chk("low width", 32'h0, w16);
        cyc(20'h00100, 1'b1);
        chk("io space", 32'h0, seen[2]);
        bus(1'b1, `OFS_LOW, 32'h0F4C);
        cyc(20'h00100, 1'b0);
        chk("row strobe", 32'h1, seen[2]);
        chk("col strobe", 32'h1, seen[4]);
        $display("test low done");
        bus(1'b1, `OFS_UPPER, 32'hF087);
        cyc(20'hFFFFF, 1'b0);
        chk("top sel", 32'h1, seen[3]);
        chk("drive off", 32'h1, seen[0]);
        chk("upper len", 32'd5, len);
        bus(1'b1, `OFS_MID, 32'h8004);
        bus(1'b1, `OFS_MIDPER, 32'h0084);
        cyc(20'h8C000, 1'b0);
        chk("mid whole", 32'h1, seen[1]);
        chk("mid len", 32'd2, len);
        $display("test upper and midrange done");
        // Low area 16-bit, midrange and I/O 8-bit, so the width source shows.
        bus(1'b1, `OFS_AUX, 32'h3);
        bus(1'b1, `OFS_MIDPER, 32'h00C4);
        bus(1'b1, `OFS_PERBASE, 32'h0009);
        cyc(20'h00100, 1'b0);
        chk("per sel", 32'h1, seen[5]);
        chk("per row strobe", 32'h1, seen[2]);
        chk("no column", 32'h0, seen[4]);
        chk("per width", 32'h1, w16);
        chk("per len", 32'd3, len);
        $display("test peripheral over dram done");
        rst(1'b0);
        dly <= 8'h00;
        bus(1'b0, `OFS_AUX, 32'h0);
        chk("aux 8-bit", 32'h8, rd);
        cyc(20'hFFFF0, 1'b0);
        chk("width8", 32'h0, w16);
        bus(1'b1, `OFS_AUX, 32'h0);
        bus(1'b0, `OFS_AUX, 32'h0);
        chk("aux write", 32'h0, rd);
        cyc(20'hFFFF0, 1'b0);
        chk("width16", 32'h1, w16);
        $display("test boot width done");
        tally_and_finish();
    end
endmodule : chip_select_decode_overlap_test

// >>> tb/cs_decode_sva.sv
// Port assertions of the chip-select decoder.
// Assumes it is bound to chip_select_decode_overlap.
module cs_decode_sva (
    input wire logic       hclk,               // Clock
    input wire logic       hresetn,            // Reset, active low
    input wire logic       cyc_start,          // Cycle start
    input wire logic       cyc_busy,           // Cycle busy
    input wire logic       cyc_done,           // Cycle done
    input wire logic       addr_drive_en,      // Address drive
    input wire logic       upper_mem_select_n, // Upper select
    input wire logic       low_mem_select_n,   // Low select
    input wire logic [3:0] mid_pin_n,          // Midrange pins
    input wire logic [6:0] periph_select_n     // Peripheral pins
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    AST_P4_NOPIN: assert property (periph_select_n[4])
        else $error("pinless peripheral select driven");
    AST_MID_LATE: assert property ($fell(mid_pin_n[0]) |-> $past(cyc_busy, 2))
        else $error("midrange select too early");
    AST_UP_IN_CYC: assert property ($fell(upper_mem_select_n) |-> $past(cyc_busy))
        else $error("upper select outside a cycle");
    AST_MIN_LEN: assert property (cyc_start && !cyc_busy |=> !cyc_done [*2])
        else $error("cycle ended too soon");
    AST_BUSY_START: assert property (cyc_start && !cyc_busy |=> cyc_busy)
        else $error("cycle not taken");
    AST_DONE_PULSE: assert property (cyc_done |=> !cyc_done)
        else $error("done longer than one cycle");
    AST_PINS_OFF: assert property ($past(cyc_done) |-> upper_mem_select_n &&
        low_mem_select_n && (&mid_pin_n) && (&periph_select_n))
        else $error("select held after cycle end");
    AST_DA: assert property ($fell(addr_drive_en) |->
        !upper_mem_select_n || !low_mem_select_n)
        else $error("address drive off without select");
    cover property ($fell(upper_mem_select_n));
    cover property ($fell(low_mem_select_n));
    cover property ($fell(mid_pin_n[0]));
endmodule : cs_decode_sva

bind chip_select_decode_overlap cs_decode_sva u_sva (.hclk, .hresetn, .cyc_start,
    .cyc_busy, .cyc_done, .addr_drive_en, .upper_mem_select_n, .low_mem_select_n,
    .mid_pin_n, .periph_select_n);

// >>> tb/cs_ready_model.sv
// Ready model of the memories behind the upper and low selects.
// Assumes active-low selects that change on rising hclk edges.
module cs_ready_model (
    input  wire logic       hclk,    // Clock
    input  wire logic       hresetn, // Reset, active low
    input  wire logic [1:0] sel_n,   // Upper and low selects
    input  wire logic [7:0] dly,     // Cycles from select to ready
    output logic            ready    // Ready back to the device
);
    logic [7:0] cnt;
    // A slow memory holds ready low, so the device must stretch the cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 8'h00;
        end else if (&sel_n) begin
            cnt <= 8'h00;
        end else if (cnt != 8'hFF) begin
            cnt <= cnt + 8'h01;
        end
    end
    assign ready = !(&sel_n) && (cnt >= dly);
endmodule : cs_ready_model
